// File: hw/rss_defs.svh
// constants for the rotate, subtract and skip datapath
//==============================================================
// Contract
// - rotate right through carry: acc gets mem>>1 with old carry on top, carry gets bit0.
// - rotate through carry changes only the carry flag.
// - subtract with borrow is acc + ~mem + carry, to acc or memory, four flags.
// - plain subtract is acc + ~mem + 1, to acc or memory, four flags.
// - immediate subtract is acc + ~imm + 1 into acc, four flags.
// - a met skip discards the prefetched instruction, taking two cycles instead of one.
// - decrement-skip writes mem-1 to memory, skips on zero, no flags.
// - decrement-to-acc-skip loads acc with mem-1, memory kept, skips on zero.
// - increment-skip writes mem+1 to memory, skips on zero, no flags.
// - increment-to-acc-skip loads acc with mem+1, memory kept, skips on zero.
// - byte set writes all ones to memory, no flags.
// - bit set forces the selected bit to one, other bits and flags kept.
// - skip-if-bit-nonzero skips when the selected bit is one, nothing modified.
// - nibble swap exchanges the two nibbles of the memory byte in place.
// - nibble swap to acc writes swapped byte into acc, memory kept.
// - skip-if-byte-zero skips when the byte is zero, nothing modified.
// - copy-and-skip copies mem into acc and skips when it is zero.
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH
`define RSS_ACC_RST    8'h00
`define RSS_FLAG_RST   4'h0
`define RSS_ALL_ONES   8'hFF
`define RSS_SKIP_CYCLES 2
`endif

// File: hw/rss_pkg.sv
// types of the rotate, subtract and skip datapath
package rss_pkg;
    typedef enum logic [3:0] {
        OP_NONE      = 4'h0,
        OP_ROT_CARRY_ACC  = 4'h1,
        OP_BORROW_SUB_ACC = 4'h2,
        OP_BORROW_SUB_MEM = 4'h3,
        OP_SUB_A     = 4'h4,
        OP_SUB_M     = 4'h5,
        OP_SUB_IMM   = 4'h6,
        OP_DEC_SKIP  = 4'h7,
        OP_DECA_SKIP = 4'h8,
        OP_INC_SKIP  = 4'h9,
        OP_INCA_SKIP = 4'hA,
        OP_SET_BYTE  = 4'hB,
        OP_SET_BIT   = 4'hC,
        OP_BIT_NZ    = 4'hD,
        OP_SWAP_M    = 4'hE,
        OP_SWAP_A    = 4'hF
    } op_t;
    // extra ops do not fit four bits, so a second select marks the two zero tests
    typedef enum logic [1:0] {
        ZT_NONE = 2'h0,
        ZT_BYTE = 2'h1,
        ZT_COPY = 2'h2
    } ztest_t;
    typedef struct packed {
        logic signed_wrap_flag;
        logic z;
        logic half_carry_flag;
        logic c;
    } flags_t;
    typedef struct packed {
        logic       valid;
        op_t        op;
        ztest_t     zt;
        logic [2:0] bit_sel;
        logic [7:0] mem;
        logic [7:0] imm;
    } issue_t;
endpackage

// File: hw/rss_datapath.sv
// execution datapath for rotate, subtract, set, swap and skip ops
`timescale 1ns/10ps
`include "rss_defs.svh"
module rss_datapath
    import rss_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   arst_n_i,
    input  wire issue_t issue_i,
    output logic [7:0]  acc_o,
    output flags_t      flags_o,
    output logic        mem_we_o,
    output logic [7:0]  mem_wdata_o,
    output logic        discard_o,
    output logic        busy_o
);
    //==============================================================
    // architectural state
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    flags_t     flags_reg;
    flags_t     flags_next;
    logic       mem_we_reg;
    logic [7:0] mem_wdata_reg;
    logic       discard_reg;
    logic       dummy_reg;

    //==============================================================
    // decode; a slot issued during the dummy cycle is dropped, since the
    // pipeline has already thrown away the instruction that sat in it
    wire logic go        = issue_i.valid && !dummy_reg;
    wire logic is_rot    = go && issue_i.zt == ZT_NONE && issue_i.op == OP_ROT_CARRY_ACC;
    wire logic is_bsub   = go && issue_i.zt == ZT_NONE &&
                           (issue_i.op == OP_BORROW_SUB_ACC || issue_i.op == OP_BORROW_SUB_MEM);
    wire logic is_sub    = go && issue_i.zt == ZT_NONE &&
                           (issue_i.op == OP_SUB_A || issue_i.op == OP_SUB_M || issue_i.op == OP_SUB_IMM);
    wire logic is_arith  = is_bsub || is_sub;
    wire logic to_mem_ar = issue_i.op == OP_BORROW_SUB_MEM || issue_i.op == OP_SUB_M;
    wire logic zt_any    = go && issue_i.zt != ZT_NONE;
    wire logic plain     = go && issue_i.zt == ZT_NONE;

    //==============================================================
    // subtract as add of the inverse; carry set means no borrow
    // split in two nibbles so the half carry falls out without a second adder
    wire logic [7:0] sub_opnd = (issue_i.op == OP_SUB_IMM) ? issue_i.imm : issue_i.mem;
    wire logic       cin      = is_bsub ? flags_reg.c : 1'b1;
    wire logic [4:0] lo_sum   = {1'b0, acc_reg[3:0]} + {1'b0, ~sub_opnd[3:0]} + {4'h0, cin};
    wire logic [4:0] hi_sum   = {1'b0, acc_reg[7:4]} + {1'b0, ~sub_opnd[7:4]} + {4'h0, lo_sum[4]};
    wire logic [7:0] diff     = {hi_sum[3:0], lo_sum[3:0]};
    wire logic       diff_wrap = (acc_reg[7] == ~sub_opnd[7]) && (diff[7] != acc_reg[7]);

    //==============================================================
    // unary results
    wire logic [7:0] dec_val  = issue_i.mem - 8'h01;
    wire logic [7:0] inc_val  = issue_i.mem + 8'h01;
    wire logic [7:0] swap_val = {issue_i.mem[3:0], issue_i.mem[7:4]};
    wire logic [7:0] rot_val  = {flags_reg.c, issue_i.mem[7:1]};
    wire logic [7:0] bit_mask = 8'h01 << issue_i.bit_sel;
    wire logic       sel_bit  = |(issue_i.mem & bit_mask);

    //==============================================================
    // skip condition, only for the skip family
    logic skip;
    always_comb begin
        skip = 1'b0;
        if (zt_any) begin
            skip = (issue_i.mem == 8'h00);
        end else if (plain) begin
            unique case (issue_i.op)
                OP_DEC_SKIP, OP_DECA_SKIP: skip = (dec_val == 8'h00);
                OP_INC_SKIP, OP_INCA_SKIP: skip = (inc_val == 8'h00);
                OP_BIT_NZ:                 skip = sel_bit;
                default:                   skip = 1'b0;
            endcase
        end
    end

    //==============================================================
    // next accumulator, memory write and flags
    // only the subtract family and the rotate touch the flag register
    logic       we_next;
    logic [7:0] wd_next;
    always_comb begin
        acc_next   = acc_reg;
        flags_next = flags_reg;
        we_next    = 1'b0;
        wd_next    = 8'h00;
        if (zt_any) begin
            if (issue_i.zt == ZT_COPY) begin
                acc_next = issue_i.mem;
            end
        end else if (plain) begin
            unique case (issue_i.op)
                OP_ROT_CARRY_ACC: begin
                    acc_next     = rot_val;
                    flags_next.c = issue_i.mem[0];
                end
                OP_BORROW_SUB_ACC, OP_BORROW_SUB_MEM, OP_SUB_A, OP_SUB_M, OP_SUB_IMM: begin
                    flags_next.signed_wrap_flag = diff_wrap;
                    flags_next.z                = (diff == 8'h00);
                    flags_next.half_carry_flag  = lo_sum[4];
                    flags_next.c                = hi_sum[4];
                    if (to_mem_ar) begin
                        we_next = 1'b1;
                        wd_next = diff;
                    end else begin
                        acc_next = diff;
                    end
                end
                OP_DEC_SKIP: begin
                    we_next = 1'b1;
                    wd_next = dec_val;
                end
                OP_DECA_SKIP: begin
                    acc_next = dec_val;
                end
                OP_INC_SKIP: begin
                    we_next = 1'b1;
                    wd_next = inc_val;
                end
                OP_INCA_SKIP: begin
                    acc_next = inc_val;
                end
                OP_SET_BYTE: begin
                    we_next = 1'b1;
                    wd_next = `RSS_ALL_ONES;
                end
                OP_SET_BIT: begin
                    we_next = 1'b1;
                    wd_next = issue_i.mem | bit_mask;
                end
                OP_SWAP_M: begin
                    we_next = 1'b1;
                    wd_next = swap_val;
                end
                OP_SWAP_A: begin
                    acc_next = swap_val;
                end
                default: begin
                    acc_next = acc_reg;
                end
            endcase
        end
    end

    //==============================================================
    // state registers; dummy marks the inserted second cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc_reg       <= `RSS_ACC_RST;
            flags_reg     <= `RSS_FLAG_RST;
            mem_we_reg    <= 1'b0;
            mem_wdata_reg <= 8'h00;
            discard_reg   <= 1'b0;
            dummy_reg     <= 1'b0;
        end else begin
            acc_reg       <= acc_next;
            flags_reg     <= flags_next;
            mem_we_reg    <= we_next;
            mem_wdata_reg <= wd_next;
            discard_reg   <= skip;
            dummy_reg     <= skip;
        end
    end

    assign acc_o       = acc_reg;
    assign flags_o     = flags_reg;
    assign mem_we_o    = mem_we_reg;
    assign mem_wdata_o = mem_wdata_reg;
    assign discard_o   = discard_reg;
    assign busy_o      = dummy_reg;

    //==============================================================
    // checks on the rotate
    rot_carry_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        is_rot |=> acc_reg == {$past(flags_reg.c), $past(issue_i.mem[7:1])} && flags_reg.c == $past(issue_i.mem[0]))
        else $error("rotate through carry result wrong");
    rot_flags_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        is_rot |=> flags_reg.signed_wrap_flag == $past(flags_reg.signed_wrap_flag)
            && flags_reg.z == $past(flags_reg.z)
            && flags_reg.half_carry_flag == $past(flags_reg.half_carry_flag) && !mem_we_reg)
        else $error("rotate changed other flags");

    //==============================================================
    // checks on the subtract family, worked out from the operands, plus the result sign for the signed wrap
    sub_carry_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (is_sub && issue_i.op == OP_SUB_A) |=> flags_reg.c == ($past(acc_reg) >= $past(issue_i.mem)))
        else $error("subtract borrow flag wrong");
    sub_result_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (is_sub && issue_i.op == OP_SUB_A) |=> acc_reg == $past(acc_reg) - $past(issue_i.mem) && !mem_we_reg)
        else $error("subtract to acc result wrong");
    sub_mem_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (is_sub && issue_i.op == OP_SUB_M) |=> mem_we_reg && acc_reg == $past(acc_reg)
            && mem_wdata_reg == $past(acc_reg) - $past(issue_i.mem))
        else $error("subtract to memory wrong");
    sub_imm_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (is_sub && issue_i.op == OP_SUB_IMM) |=> acc_reg == $past(acc_reg) - $past(issue_i.imm)
            && flags_reg.c == ($past(acc_reg) >= $past(issue_i.imm)))
        else $error("immediate subtract wrong");
    sbc_acc_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (is_bsub && issue_i.op == OP_BORROW_SUB_ACC) |=> !mem_we_reg
            && acc_reg == $past(acc_reg) + ~$past(issue_i.mem) + $past(flags_reg.c))
        else $error("borrow subtract to acc wrong");
    sbc_mem_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (is_bsub && issue_i.op == OP_BORROW_SUB_MEM) |=> mem_we_reg && acc_reg == $past(acc_reg))
        else $error("borrow subtract to memory touched acc");
    half_borrow_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (is_sub && issue_i.op == OP_SUB_A) |=> flags_reg.half_carry_flag == ($past(acc_reg[3:0]) >= $past(issue_i.mem[3:0]))
            && flags_reg.z == ($past(acc_reg) == $past(issue_i.mem)))
        else $error("half carry or zero flag wrong");
    signed_wrap_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (is_sub && issue_i.op == OP_SUB_A) |=> flags_reg.signed_wrap_flag ==
            (($past(acc_reg[7]) != $past(issue_i.mem[7])) && (acc_reg[7] != $past(acc_reg[7]))))
        else $error("signed wrap flag wrong");

    //==============================================================
    // checks on the skip timing
    skip_two_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        skip |=> discard_o ##1 !discard_o)
        else $error("skip did not take exactly two cycles");
    noskip_one_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (go && !skip) |=> !discard_o)
        else $error("unmet skip stalled");
    dummy_drop_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        busy_o |=> !mem_we_reg && acc_reg == $past(acc_reg) && flags_reg == $past(flags_reg))
        else $error("issue in dummy cycle was executed");

    //==============================================================
    // checks on the counting skips, set, swap and test ops
    dec_skip_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (plain && issue_i.op == OP_DEC_SKIP) |=> mem_we_reg && mem_wdata_reg == $past(issue_i.mem) - 8'h01
            && discard_o == ($past(issue_i.mem) == 8'h01) && flags_reg == $past(flags_reg))
        else $error("decrement skip wrong");
    dec_acc_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (plain && issue_i.op == OP_DECA_SKIP) |=> !mem_we_reg && acc_reg == $past(issue_i.mem) - 8'h01
            && discard_o == ($past(issue_i.mem) == 8'h01) && flags_reg == $past(flags_reg))
        else $error("decrement to acc wrong");
    inc_skip_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (plain && issue_i.op == OP_INC_SKIP) |=> mem_we_reg && mem_wdata_reg == $past(issue_i.mem) + 8'h01
            && discard_o == ($past(issue_i.mem) == 8'hFF) && flags_reg == $past(flags_reg))
        else $error("increment skip wrong");
    inc_acc_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (plain && issue_i.op == OP_INCA_SKIP) |=> !mem_we_reg && acc_reg == $past(issue_i.mem) + 8'h01)
        else $error("increment to acc wrong");
    set_byte_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (plain && issue_i.op == OP_SET_BYTE) |=> mem_we_reg && mem_wdata_reg == 8'hFF
            && flags_reg == $past(flags_reg))
        else $error("byte set wrong");
    set_bit_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (plain && issue_i.op == OP_SET_BIT) |=> mem_we_reg
            && mem_wdata_reg == ($past(issue_i.mem) | (8'h01 << $past(issue_i.bit_sel))))
        else $error("bit set wrong");
    bit_skip_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (plain && issue_i.op == OP_BIT_NZ) |=> !mem_we_reg
            && discard_o == $past(issue_i.mem[issue_i.bit_sel]))
        else $error("bit test skip wrong");
    swap_mem_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (plain && issue_i.op == OP_SWAP_M) |=> mem_we_reg
            && mem_wdata_reg == {$past(issue_i.mem[3:0]), $past(issue_i.mem[7:4])})
        else $error("nibble swap in memory wrong");
    swap_acc_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (plain && issue_i.op == OP_SWAP_A) |=> !mem_we_reg
            && acc_reg == {$past(issue_i.mem[3:0]), $past(issue_i.mem[7:4])})
        else $error("nibble swap to acc wrong");
    zero_skip_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (zt_any && issue_i.zt == ZT_BYTE) |=> !mem_we_reg && acc_reg == $past(acc_reg)
            && discard_o == ($past(issue_i.mem) == 8'h00))
        else $error("byte zero skip wrong");
    copy_skip_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (zt_any && issue_i.zt == ZT_COPY) |=> acc_reg == $past(issue_i.mem) && !mem_we_reg)
        else $error("copy and skip wrong");
endmodule

// File: test/rss_mem_model.sv
// one byte of data memory that feeds the operand and takes write-backs
`timescale 1ns/10ps
module rss_mem_model (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       load_i,
    input  wire logic [7:0] load_data_i,
    input  wire logic       we_i,
    input  wire logic [7:0] wdata_i,
    output logic [7:0]      rdata_o
);
    logic [7:0] cell_reg;
    // a write-back wins over a preload, so a lost write shows as a stale byte
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) cell_reg <= 8'h00;
        else if (we_i) cell_reg <= wdata_i;
        else if (load_i) cell_reg <= load_data_i;
    end
    assign rdata_o = cell_reg;
endmodule

// File: test/rss_datapath_test.sv
// self-checking bench for the rotate, subtract, set, swap and skip datapath
`timescale 1ns/10ps
module rss_datapath_test;
    import rss_pkg::*;
    logic       clk_i = 1'b0;
    logic       arst_n_i = 1'b0;
    logic       ld = 1'b0;
    logic [7:0] ld_d = 8'h00;
    logic [7:0] mem_rd, acc_o, mem_wdata_o;
    logic [7:0] acc_e = 8'h00;
    flags_t     flags_o;
    flags_t     fl_e = '0;
    logic       mem_we_o, discard_o, busy_o;
    issue_t     drv = '0;
    issue_t     iss;
    int         mismatches = 0;
    int         n_checks = 0;
    int         cycles = 0;
    // the operand byte always comes from the memory model, never from the bench
    assign iss = {drv.valid, drv.op, drv.zt, drv.bit_sel, mem_rd, drv.imm};
    rss_datapath dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .issue_i(iss), .acc_o(acc_o), .flags_o(flags_o),
        .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .discard_o(discard_o), .busy_o(busy_o));
    rss_mem_model mem (.clk_i(clk_i), .arst_n_i(arst_n_i), .load_i(ld), .load_data_i(ld_d), .we_i(mem_we_o),
        .wdata_i(mem_wdata_o), .rdata_o(mem_rd));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // a hung run is cut short and counted as a mismatch
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic chk_b(string name, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_f(flags_t exp, flags_t got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error flags expected %h seen %h", exp, got);
        end
    endtask
    // one instruction: preload memory, issue, judge outputs, then judge memory
    task automatic step(op_t op, ztest_t zt, logic [2:0] b, logic [7:0] m, logic [7:0] x);
        logic [7:0] o, v;
        logic [8:0] r;
        logic [4:0] h;
        logic       cin, we, sk;
        o = (op == OP_SUB_IMM) ? x : m;
        cin = (op == OP_BORROW_SUB_ACC || op == OP_BORROW_SUB_MEM) ? fl_e.c : 1'b1;
        r = {1'b0, acc_e} + {1'b0, ~o} + 9'(cin);
        h = {1'b0, acc_e[3:0]} + {1'b0, ~o[3:0]} + 5'(cin);
        case (op)
            OP_DEC_SKIP, OP_DECA_SKIP: v = m - 8'h01;
            OP_INC_SKIP, OP_INCA_SKIP: v = m + 8'h01;
            OP_SET_BYTE: v = 8'hFF;
            OP_SET_BIT: v = m | (8'h01 << b);
            OP_SWAP_M, OP_SWAP_A: v = {m[3:0], m[7:4]};
            OP_ROT_CARRY_ACC: v = {fl_e.c, m[7:1]};
            default: v = r[7:0];
        endcase
        we = (zt == ZT_NONE) && (op inside {OP_BORROW_SUB_MEM, OP_SUB_M, OP_DEC_SKIP, OP_INC_SKIP, OP_SET_BYTE, OP_SET_BIT,
            OP_SWAP_M});
        sk = (op inside {OP_DEC_SKIP, OP_DECA_SKIP, OP_INC_SKIP, OP_INCA_SKIP} && v == 8'h00) || (op == OP_BIT_NZ && m[b]);
        if (zt != ZT_NONE) begin
            sk = (m == 8'h00);
            if (zt == ZT_COPY) acc_e = m;
        end else begin
            if (op inside {OP_BORROW_SUB_ACC, OP_BORROW_SUB_MEM, OP_SUB_A, OP_SUB_M, OP_SUB_IMM})
                fl_e = '{signed_wrap_flag: (acc_e[7] != o[7]) && (r[7] != acc_e[7]), z: (r[7:0] == 8'h00),
                         half_carry_flag: h[4], c: r[8]};
            if (op == OP_ROT_CARRY_ACC) fl_e.c = m[0];
            if (!we && !(op inside {OP_BIT_NZ, OP_NONE})) acc_e = v;
        end
        @(posedge clk_i);
        ld <= 1'b1;
        ld_d <= m;
        @(posedge clk_i);
        ld <= 1'b0;
        drv <= '{valid: 1'b1, op: op, zt: zt, bit_sel: b, mem: 8'h00, imm: x};
        @(posedge clk_i);
        drv.valid <= 1'b0;
        #1;
        chk_b("acc", acc_e, acc_o);
        chk_f(fl_e, flags_o);
        chk_b("mem_we", {7'h00, we}, {7'h00, mem_we_o});
        chk_b("wdata", we ? v : 8'h00, mem_wdata_o);
        chk_b("discard busy", {6'h00, sk, sk}, {6'h00, discard_o, busy_o});
        @(posedge clk_i);
        #1;
        chk_b("discard busy end", 8'h00, {6'h00, discard_o, busy_o});
        chk_b("mem", we ? v : m, mem_rd);
    endtask
    // flags are primed by a subtract so an unwanted rotate side effect shows
    task automatic t_rotate();
        step(OP_NONE, ZT_COPY, 3'h0, 8'h80, 8'h00);
        step(OP_SUB_A, ZT_NONE, 3'h0, 8'h01, 8'h00);
        step(OP_ROT_CARRY_ACC, ZT_NONE, 3'h0, 8'h01, 8'h00);
        step(OP_ROT_CARRY_ACC, ZT_NONE, 3'h0, 8'hFE, 8'h00);
    endtask
    task automatic t_sub();
        step(OP_BORROW_SUB_ACC, ZT_NONE, 3'h0, 8'hFF, 8'h00);
        step(OP_SUB_IMM, ZT_NONE, 3'h0, 8'h55, 8'h7F);
        step(OP_BORROW_SUB_MEM, ZT_NONE, 3'h0, 8'h00, 8'h00);
        step(OP_BORROW_SUB_ACC, ZT_NONE, 3'h0, 8'h01, 8'h00);
        step(OP_SUB_M, ZT_NONE, 3'h0, 8'h7F, 8'h00);
        step(OP_SUB_IMM, ZT_NONE, 3'h0, 8'h00, 8'h08);
    endtask
    // each counting skip where it reaches zero; decrement-skip and increment-to-acc-skip also one step off
    task automatic t_skip();
        step(OP_DEC_SKIP, ZT_NONE, 3'h0, 8'h01, 8'h00);
        step(OP_DEC_SKIP, ZT_NONE, 3'h0, 8'h00, 8'h00);
        step(OP_DECA_SKIP, ZT_NONE, 3'h0, 8'h01, 8'h00);
        step(OP_INC_SKIP, ZT_NONE, 3'h0, 8'hFF, 8'h00);
        step(OP_INCA_SKIP, ZT_NONE, 3'h0, 8'hFE, 8'h00);
        step(OP_INCA_SKIP, ZT_NONE, 3'h0, 8'hFF, 8'h00);
        for (int i = 0; i < 8; i++) begin
            step(OP_BIT_NZ, ZT_NONE, 3'(i), 8'h01 << i, 8'h00);
            step(OP_BIT_NZ, ZT_NONE, 3'(i), ~(8'h01 << i), 8'h00);
        end
        step(OP_NONE, ZT_BYTE, 3'h0, 8'h00, 8'h00);
        step(OP_NONE, ZT_BYTE, 3'h0, 8'h80, 8'h00);
        step(OP_NONE, ZT_COPY, 3'h0, 8'h00, 8'h00);
    endtask
    task automatic t_set_swap();
        step(OP_SET_BYTE, ZT_NONE, 3'h0, 8'h12, 8'h00);
        for (int i = 0; i < 8; i++) step(OP_SET_BIT, ZT_NONE, 3'(i), 8'h00, 8'h00);
        step(OP_SWAP_M, ZT_NONE, 3'h0, 8'h3C, 8'h00);
        step(OP_SWAP_A, ZT_NONE, 3'h0, 8'hA1, 8'h00);
    endtask
    // an issue held into the dummy cycle must be dropped
    task automatic t_refuse();
        @(posedge clk_i);
        ld <= 1'b1;
        ld_d <= 8'h01;
        @(posedge clk_i);
        ld <= 1'b0;
        drv <= '{valid: 1'b1, op: OP_DEC_SKIP, zt: ZT_NONE, bit_sel: 3'h0, mem: 8'h00, imm: 8'h00};
        @(posedge clk_i);
        drv.op <= OP_SET_BYTE;
        #1;
        chk_b("discard", 8'h01, {7'h00, discard_o});
        @(posedge clk_i);
        drv.valid <= 1'b0;
        #1;
        chk_b("refused we", 8'h00, {7'h00, mem_we_o});
        chk_b("refused mem", 8'h00, mem_rd);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_rotate();
        t_sub();
        t_skip();
        t_set_swap();
        t_refuse();
        close_out();
    end
endmodule
